// file: timer_pwm_pkg.sv
// Shared constants, types and helpers for the PWM and capture timer
package timer_pwm_pkg;

    localparam int CNT_W = 16;
    localparam int PRE_W = 3;
    localparam int PRE_CNT_W = 7;
    localparam int DB_W = 8;
    localparam int MODE_W = 4;
    localparam int ISRC_W = 2;

    // Values after reset and at restart, and the dead-band clamp limit
    localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_RESTART = 16'h0001;
    localparam logic [CNT_W-1:0] PWM_RST = 16'h0000;
    localparam logic [PRE_CNT_W-1:0] PRE_RST = 7'h00;
    localparam logic [DB_W-1:0] DB_CNT_RST = 8'h00;
    localparam logic [DB_W-1:0] DB_MAX = 8'h80;

    // Effective mode is {mode_high_bit, mode field}
    localparam logic [MODE_W-1:0] MODE_PWM_SINGLE = 4'h3;
    localparam logic [MODE_W-1:0] MODE_CAPTURE = 4'h4;
    localparam logic [MODE_W-1:0] MODE_PWM_DUAL = 4'hC;

    // Interrupt source selection
    localparam logic [ISRC_W-1:0] ISRC_BOTH = 2'h0;
    localparam logic [ISRC_W-1:0] ISRC_BOTH_ALT = 2'h1;
    localparam logic [ISRC_W-1:0] ISRC_CAPTURE_ONLY = 2'h2;
    localparam logic [ISRC_W-1:0] ISRC_RELOAD_ONLY = 2'h3;

    // PWM period phase: before match, after match
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_LEAD = 2'b01,
        PH_TRAIL = 2'b11
    } phase_t;

    function automatic logic is_pwm_mode(input logic [MODE_W-1:0] m);
        return (m == MODE_PWM_SINGLE) || (m == MODE_PWM_DUAL);
    endfunction

    // Prescaler wrap value: divide by 2**p
    function automatic logic [PRE_CNT_W-1:0] pre_limit(input logic [PRE_W-1:0] p);
        return PRE_CNT_W'((8'h01 << p) - 8'h01);
    endfunction

endpackage

// file: timer_deadband.sv
// Dead-band delay on the inactive-to-active edge of one PWM line
`timescale 1ns/1ps
module timer_deadband
    import timer_pwm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    input wire logic [DB_W-1:0] delay_i,
    output logic level_o
);

    logic out_q;
    logic out_d;
    logic [DB_W-1:0] cnt_q;
    logic [DB_W-1:0] cnt_d;

    // Falls pass at once, rises wait delay_i extra cycles
    always_comb
    begin
        out_d = out_q;
        cnt_d = cnt_q;
        if (!level_i)
        begin
            out_d = 1'b0;
            cnt_d = DB_CNT_RST;
        end
        else if (!out_q)
        begin
            if (cnt_q >= delay_i)
            begin
                out_d = 1'b1;
            end
            else
            begin
                cnt_d = DB_W'(cnt_q + 8'h01);
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            out_q <= 1'b0;
            cnt_q <= DB_CNT_RST;
        end
        else
        begin
            out_q <= out_d;
            cnt_q <= cnt_d;
        end
    end

    assign level_o = out_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    fall_fast_a: assert property (!level_i |=> !out_q)
        else $error("dead-band output did not fall with its input");
    rise_hold_a: assert property (level_i && !out_q && cnt_q < delay_i |=> !out_q)
        else $error("dead-band output rose before the delay ran out");

endmodule

// file: timer_pwm_capture.sv
// 16-bit timer with single PWM, dual PWM with dead-band, and capture modes
`timescale 1ns/1ps
module timer_pwm_capture
    import timer_pwm_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic enable_i,
    input wire logic [2:0] mode_i,
    input wire logic mode_high_bit_i,
    input wire logic output_polarity_select_i,
    input wire logic [PRE_W-1:0] prescale_i,
    input wire logic [ISRC_W-1:0] interrupt_source_config_i,
    input wire logic [CNT_W-1:0] reload_i,
    input wire logic [DB_W-1:0] deadband_i,
    input wire logic count_wr_i,
    input wire logic [CNT_W-1:0] count_wdata_i,
    input wire logic pwm_wr_i,
    input wire logic [CNT_W-1:0] pwm_wdata_i,
    input wire logic timer_in_i,
    output logic timer_out_o,
    output logic timer_out_comp_o,
    output logic comp_pin_oe_o,
    output logic irq_o,
    output logic input_capture_flag_o,
    output logic [CNT_W-1:0] count_o,
    output logic [CNT_W-1:0] pwm_o
);

    logic [MODE_W-1:0] mode_eff;
    logic pwm_mode;
    logic dual_mode;
    logic cap_mode;
    logic run;
    logic tick;
    logic reload_hit;
    logic match_next;
    logic edge_rise;
    logic edge_fall;
    logic cap_ev;
    logic output_polarity_select;
    logic [CNT_W-1:0] count_inc;
    logic [DB_W-1:0] db_eff;
    logic [1:0] db_in;
    logic [1:0] db_out;

    // Input synchroniser and edge history
    logic in_s1_q;
    logic in_s2_q;
    logic in_s3_q;

    logic [PRE_CNT_W-1:0] pre_q;
    logic [PRE_CNT_W-1:0] pre_d;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic [CNT_W-1:0] pwm_q;
    logic [CNT_W-1:0] pwm_d;
    phase_t phase_q;
    phase_t phase_d;
    logic lvl_q;
    logic lvl_d;
    logic flag_q;
    logic flag_d;
    logic irq_q;
    logic irq_d;
    logic comp_oe_q;
    logic comp_oe_d;

    assign output_polarity_select = output_polarity_select_i;
    assign mode_eff = {mode_high_bit_i, mode_i};
    assign pwm_mode = is_pwm_mode(mode_eff);
    assign dual_mode = (mode_eff == MODE_PWM_DUAL);
    assign cap_mode = (mode_eff == MODE_CAPTURE);
    assign run = enable_i && (pwm_mode || cap_mode);
    assign tick = run && (pre_q == pre_limit(prescale_i));
    assign reload_hit = tick && (count_q == reload_i);
    assign count_inc = CNT_W'(count_q + 16'h0001);
    assign match_next = (count_inc == pwm_q);
    assign edge_rise = in_s2_q && !in_s3_q;
    assign edge_fall = !in_s2_q && in_s3_q;
    // Polarity one selects the rising edge
    assign cap_ev = enable_i && cap_mode && (output_polarity_select ? edge_rise : edge_fall);

    // Prescaler
    always_comb
    begin
        pre_d = pre_q;
        if (!run || tick)
        begin
            pre_d = PRE_RST;
        end
        else
        begin
            pre_d = PRE_CNT_W'(pre_q + 7'h01);
        end
    end

    // Count, PWM phase, capture register and interrupt
    always_comb
    begin
        count_d = count_q;
        pwm_d = pwm_q;
        phase_d = phase_q;
        lvl_d = lvl_q;
        flag_d = flag_q;
        irq_d = 1'b0;
        comp_oe_d = dual_mode;
        if (count_wr_i)
        begin
            count_d = count_wdata_i;
        end
        else if (reload_hit)
        begin
            count_d = COUNT_RESTART;
        end
        else if (tick)
        begin
            count_d = count_inc;
        end
        if (pwm_wr_i)
        begin
            pwm_d = pwm_wdata_i;
        end
        if (!enable_i || !pwm_mode)
        begin
            phase_d = PH_IDLE;
            lvl_d = output_polarity_select;
        end
        else
        begin
            unique case (phase_q)
                PH_IDLE:
                begin
                    phase_d = PH_LEAD;
                    lvl_d = output_polarity_select;
                    // First tick after enable may already land on the match
                    if (tick && match_next && !reload_hit)
                    begin
                        lvl_d = !output_polarity_select;
                        phase_d = PH_TRAIL;
                    end
                end
                PH_LEAD:
                begin
                    if (reload_hit)
                    begin
                        lvl_d = output_polarity_select;
                    end
                    else if (tick && match_next)
                    begin
                        lvl_d = !lvl_q;
                        phase_d = PH_TRAIL;
                    end
                end
                PH_TRAIL:
                begin
                    if (reload_hit)
                    begin
                        lvl_d = output_polarity_select;
                        phase_d = PH_LEAD;
                    end
                end
                default:
                begin
                    phase_d = PH_IDLE;
                end
            endcase
            if (reload_hit)
            begin
                irq_d = 1'b1;
            end
        end
        if (enable_i && cap_mode)
        begin
            if (reload_hit)
            begin
                flag_d = 1'b0;
                if (interrupt_source_config_i != ISRC_CAPTURE_ONLY)
                begin
                    irq_d = 1'b1;
                end
            end
            // Capture wins over a write or a reload in the same cycle
            if (cap_ev)
            begin
                pwm_d = count_q;
                flag_d = 1'b1;
                if (interrupt_source_config_i != ISRC_RELOAD_ONLY)
                begin
                    irq_d = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            in_s1_q <= 1'b0;
            in_s2_q <= 1'b0;
            in_s3_q <= 1'b0;
            pre_q <= PRE_RST;
            count_q <= COUNT_RST;
            pwm_q <= PWM_RST;
            phase_q <= PH_IDLE;
            lvl_q <= 1'b0;
            flag_q <= 1'b0;
            irq_q <= 1'b0;
            comp_oe_q <= 1'b0;
        end
        else
        begin
            in_s1_q <= timer_in_i;
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q;
            pre_q <= pre_d;
            count_q <= count_d;
            pwm_q <= pwm_d;
            phase_q <= phase_d;
            lvl_q <= lvl_d;
            flag_q <= flag_d;
            irq_q <= irq_d;
            comp_oe_q <= comp_oe_d;
        end
    end

    // Dead-band applies only in dual mode, clamped to its range
    assign db_eff = dual_mode ? ((deadband_i > DB_MAX) ? DB_MAX : deadband_i) : DB_CNT_RST;
    assign db_in[0] = lvl_q;
    assign db_in[1] = dual_mode && !lvl_q;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_line
            timer_deadband u_db (
                .clk_sys_i(clk_sys_i),
                .rst_n_i(rst_n_i),
                .level_i(db_in[gi]),
                .delay_i(db_eff),
                .level_o(db_out[gi])
            );
        end
    endgenerate

    assign timer_out_o = db_out[0];
    assign timer_out_comp_o = db_out[1];
    assign comp_pin_oe_o = comp_oe_q;
    assign irq_o = irq_q;
    assign input_capture_flag_o = flag_q;
    assign count_o = count_q;
    assign pwm_o = pwm_q;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence reload_seq;
        reload_hit && !count_wr_i;
    endsequence

    sequence match_seq;
        enable_i && pwm_mode && phase_q == PH_LEAD && tick && match_next && !reload_hit;
    endsequence

    reload_restart_a: assert property (reload_seq |=> count_q == COUNT_RESTART)
        else $error("count did not restart after reload");
    reload_irq_a: assert property (reload_seq ##0 pwm_mode |=> irq_q)
        else $error("no interrupt at PWM reload");
    match_toggle_a: assert property (match_seq |=> lvl_q != $past(lvl_q))
        else $error("PWM output did not toggle at match");
    pol_high_a: assert property (reload_seq ##0 pwm_mode && output_polarity_select && db_eff == DB_CNT_RST
        |=> lvl_q ##1 timer_out_o)
        else $error("output not high after reload with polarity one");
    pol_low_a: assert property (reload_seq ##0 pwm_mode && !output_polarity_select |=> !lvl_q ##1 !timer_out_o)
        else $error("output not low after reload with polarity zero");
    count_step_a: assert property (tick && !reload_hit && !count_wr_i
        |=> count_q == CNT_W'($past(count_q) + 16'h0001))
        else $error("count did not advance on a tick");
    no_tick_hold_a: assert property (!tick && !count_wr_i |=> $stable(count_q))
        else $error("count moved without a tick");
    capture_copy_a: assert property (cap_ev |=> pwm_q == $past(count_q))
        else $error("capture did not copy the count");
    capture_flag_a: assert property (cap_ev && !count_wr_i
        |=> input_capture_flag_o && count_q != COUNT_RST)
        else $error("capture flag not set");
    reload_clear_a: assert property (cap_mode && enable_i && reload_hit && !cap_ev
        |=> !input_capture_flag_o && irq_q == (interrupt_source_config_i != ISRC_CAPTURE_ONLY))
        else $error("capture-mode reload mishandled");
    irq_source_a: assert property (cap_ev && !reload_hit
        && interrupt_source_config_i == ISRC_RELOAD_ONLY |=> !irq_q)
        else $error("capture interrupt not masked by source select");
    comp_function_a: assert property (dual_mode |=> comp_pin_oe_o)
        else $error("second pin not switched to output in dual mode");
    no_overlap_a: assert property (dual_mode && $stable(dual_mode)
        |-> !(timer_out_o && timer_out_comp_o))
        else $error("both PWM lines active together");

endmodule

// file: timer_pin_model.sv
// External pin model: drives the shared capture pin, yields it in dual mode
`timescale 1ns/1ps
module timer_pin_model
(
    input wire logic clk_sys_i,
    input wire logic comp_i,
    input wire logic comp_oe_i,
    output logic pin_o
);
    logic ext_q = 1'b0;

    task automatic set_level(input logic v);
        @(posedge clk_sys_i);
        #1;
        ext_q = v;
    endtask

    // Complement output owns the pin while enabled
    assign pin_o = comp_oe_i ? comp_i : ext_q;
endmodule

// file: tb_timer_pwm_capture.sv
// Self-checking bench for the PWM and capture timer
`timescale 1ns/1ps
module tb_timer_pwm_capture;
    import timer_pwm_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic enable_i = 1'b0;
    logic [2:0] mode_i = 3'h0;
    logic mode_high_bit_i = 1'b0;
    logic output_polarity_select_i = 1'b0;
    logic [PRE_W-1:0] prescale_i = 3'h0;
    logic [ISRC_W-1:0] interrupt_source_config_i = 2'h0;
    logic [CNT_W-1:0] reload_i = 16'h0000;
    logic [DB_W-1:0] deadband_i = 8'h00;
    logic count_wr_i = 1'b0;
    logic [CNT_W-1:0] count_wdata_i = 16'h0000;
    logic pwm_wr_i = 1'b0;
    logic [CNT_W-1:0] pwm_wdata_i = 16'h0000;
    logic pin_lvl, timer_out_o, timer_out_comp_o, comp_pin_oe_o, irq_o, input_capture_flag_o;
    logic [CNT_W-1:0] count_o, pwm_o;
    int n_mismatch = 0;
    int num_checks = 0;
    int irq_cnt = 0;

    always #4 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (irq_o === 1'b1) irq_cnt <= irq_cnt + 1;

    timer_pin_model pin_u (.clk_sys_i(clk_sys_i), .comp_i(timer_out_comp_o),
        .comp_oe_i(comp_pin_oe_o), .pin_o(pin_lvl));

    timer_pwm_capture dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .enable_i(enable_i),
        .mode_i(mode_i), .mode_high_bit_i(mode_high_bit_i),
        .output_polarity_select_i(output_polarity_select_i), .prescale_i(prescale_i),
        .interrupt_source_config_i(interrupt_source_config_i), .reload_i(reload_i),
        .deadband_i(deadband_i), .count_wr_i(count_wr_i), .count_wdata_i(count_wdata_i),
        .pwm_wr_i(pwm_wr_i), .pwm_wdata_i(pwm_wdata_i), .timer_in_i(pin_lvl),
        .timer_out_o(timer_out_o), .timer_out_comp_o(timer_out_comp_o),
        .comp_pin_oe_o(comp_pin_oe_o), .irq_o(irq_o),
        .input_capture_flag_o(input_capture_flag_o), .count_o(count_o), .pwm_o(pwm_o));

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        chk16({15'h0000, got}, {15'h0000, exp}, what);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Disable, set mode and values, write start count and PWM value, enable
    task automatic cfg(input logic [2:0] m, input logic hb, input logic pol, input logic [2:0] p,
        input logic [1:0] isrc, input logic [15:0] rl, input logic [7:0] db,
        input logic [15:0] st, input logic [15:0] pw);
        enable_i = 1'b0;
        step(1);
        mode_i = m;
        mode_high_bit_i = hb;
        output_polarity_select_i = pol;
        prescale_i = p;
        interrupt_source_config_i = isrc;
        reload_i = rl;
        deadband_i = db;
        count_wr_i = 1'b1;
        count_wdata_i = st;
        pwm_wr_i = 1'b1;
        pwm_wdata_i = pw;
        step(1);
        count_wr_i = 1'b0;
        pwm_wr_i = 1'b0;
        step(1);
        enable_i = 1'b1;
    endtask

    task automatic t_single(input logic pol);
        logic [15:0] c;
        logic lvl, lvl_d, rl;
        c = 16'h0002;
        lvl = pol;
        cfg(3'h3, 1'b0, pol, 3'h0, 2'h0, 16'h0006, 8'h00, 16'h0002, 16'h0003);
        for (int k = 0; k < 20; k++)
        begin
            step(1);
            rl = (c == 16'h0006);
            c = rl ? 16'h0001 : c + 16'h0001;
            lvl_d = lvl;
            if (c == 16'h0003)
                lvl = ~pol;
            else if (rl)
                lvl = pol;
            chk16(count_o, c, "count");
            chk1(irq_o, rl, "reload irq");
            if (k >= 2)
                chk1(timer_out_o, lvl_d, "pwm level");
            chk1(timer_out_comp_o, 1'b0, "comp idle");
        end
        $display("single pwm polarity %0d done", pol);
    endtask

    task automatic t_prescale;
        logic [15:0] c0;
        int n;
        cfg(3'h3, 1'b0, 1'b0, 3'h2, 2'h0, 16'h0100, 8'h00, 16'h0001, 16'h0080);
        c0 = count_o;
        for (n = 0; n < 10 && count_o === c0; n++) step(1);
        c0 = count_o;
        for (n = 0; n < 10 && count_o === c0; n++) step(1);
        chk16(16'(n), 16'h0004, "tick spacing");
        chk16(count_o, c0 + 16'h0001, "tick step");
        $display("prescale done");
    endtask

    task automatic t_dual(input logic [7:0] db);
        int n, ovl;
        cfg(3'h4, 1'b1, 1'b1, 3'h0, 2'h0, 16'h0032, db, 16'h0001, 16'h0014);
        step(3);
        chk1(comp_pin_oe_o, 1'b1, "pin turned");
        chk1(pin_lvl, timer_out_comp_o, "pin carries comp");
        for (n = 0; n < 100 && timer_out_o !== 1'b1; n++) step(1);
        for (n = 0; n < 100 && timer_out_o !== 1'b0; n++) step(1);
        for (n = 0; n < 200 && timer_out_comp_o !== 1'b1; n++) step(1);
        chk16(16'(n), {8'h00, db}, "comp rise delay");
        for (n = 0; n < 100 && timer_out_comp_o !== 1'b0; n++) step(1);
        for (n = 0; n < 200 && timer_out_o !== 1'b1; n++) step(1);
        chk16(16'(n), {8'h00, db}, "out rise delay");
        ovl = 0;
        for (n = 0; n < 110; n++)
        begin
            step(1);
            if (timer_out_o !== 1'b0 && timer_out_comp_o !== 1'b0) ovl++;
        end
        chk16(16'(ovl), 16'h0000, "outputs overlap");
        $display("dual pwm deadband %0d done", db);
    endtask

    task automatic t_capture(input logic [1:0] isrc, input logic pol);
        int ir0, n;
        logic [15:0] cap;
        enable_i = 1'b0;
        pin_u.set_level(~pol);
        step(4);
        cfg(3'h4, 1'b0, pol, 3'h0, isrc, 16'h0028, 8'h00, 16'h0001, 16'h0000);
        ir0 = irq_cnt;
        step(7);
        pin_u.set_level(pol);
        for (n = 0; n < 10 && input_capture_flag_o !== 1'b1; n++) step(1);
        cap = pwm_o;
        chk1(input_capture_flag_o, 1'b1, "capture flag");
        chk1(cap >= 16'h000A && cap <= 16'h000D, 1'b1, "captured count");
        step(2);
        chk16(16'(irq_cnt - ir0), {15'h0000, isrc != 2'h3}, "capture irq");
        chk1(count_o > cap, 1'b1, "count kept");
        for (n = 0; n < 60 && count_o !== 16'h0001; n++) step(1);
        step(2);
        chk1(input_capture_flag_o, 1'b0, "flag cleared");
        chk16(16'(irq_cnt - ir0), 16'(int'(isrc != 2'h3) + int'(isrc != 2'h2)), "irq total");
        chk16(pwm_o, cap, "capture held");
        $display("capture source %0d done", isrc);
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end

    initial
    begin
        step(6);
        rst_n_i = 1'b1;
        chk16(count_o, 16'h0000, "count reset");
        chk16(pwm_o, 16'h0000, "pwm reset");
        chk1(irq_o, 1'b0, "irq reset");
        t_single(1'b1);
        t_single(1'b0);
        t_prescale();
        t_dual(8'h00);
        t_dual(8'h05);
        for (int i = 0; i < 4; i++)
            t_capture(2'(i), i[0]);
        tally_and_finish();
    end
endmodule
